/* rtl/pfb_branch_unit.sv */
// Program-flow branch unit: jumps, invokes, exits, compares, skips and
// flag branches with their cycle counts. Keeps the program counter.
// Assumes operands, status flags, Z and stack word arrive from same-clock
// core logic, and that the decoder holds off issue while BUSY_OUT is high.
//
// Notes on behaviour
// RULE1: Indirect jump loads PC from Z, no flag change, 2 cycles.
// RULE2: Indirect invoke sets PC to Z, flags untouched, 3 cycles.
// RULE3: Compare-skip-equal skips next instruction when equal, 1/2/3 cycles.
// RULE4: Compare-immediate sets Z,N,V,C,H from Rd minus K, one cycle.
// RULE5: Skip when register bit clear, PC plus 2 or 3, 1/2/3 cycles.
// RULE6: Skip when register bit set, PC plus 2 or 3, 1/2/3 cycles.
// RULE7: Skip when I/O bit clear, PC plus 2 or 3, 1/2/3 cycles.
// RULE8: Skip when I/O bit set, PC plus 2 or 3.
// RULE9: Branch when flag s set, PC plus k plus 1, 1/2 cycles.
// RULE10: Branch when flag s clear, PC plus k plus 1, 1/2 cycles.
// RULE11: Branch when carry clear, PC plus k plus 1, 1/2 cycles.
// RULE12: Branch when N xor V is 0.
// RULE13: Branch when N xor V is 1, 1/2 cycles.
// RULE14: Branch when half-carry set, 1 cycle untaken, 2 taken.
// RULE15: Branch when half-carry clear, 1/2 cycles.
// RULE16: Branch when T flag clear, 1/2 cycles.
// RULE17: Branch when overflow set, 1/2 cycles, no flag change.
// RULE18: Branch when overflow clear, 1/2 cycles.
// RULE19: Relative jump 2, absolute 3, relative invoke 3, direct invoke 4 cycles.
// RULE20: Exits reload PC from stack in 4 cycles; interrupt exit sets I.
`default_nettype none

module pfb_branch_unit (
	input  wire logic                  CLK_IN,
	input  wire logic                  RESETN_IN,
	input  wire pfb_pkg::pfb_issue_t   ISSUE_IN,
	input  wire logic [7:0]            FLAGS_IN,
	input  wire logic [pfb_pkg::PC_W-1:0] Z_PTR_IN,
	input  wire logic [pfb_pkg::PC_W-1:0] STACK_IN,
	output var  logic [pfb_pkg::PC_W-1:0] PC_OUT,
	output var  logic [7:0]            FLAGS_OUT,
	output var  logic                  FLAGS_WE_OUT,
	output var  logic                  BUSY_OUT,
	output var  logic                  DONE_OUT,
	output var  logic                  PUSH_OUT,
	output var  logic [pfb_pkg::PC_W-1:0] RET_ADDR_OUT
);
	import pfb_pkg::*;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------

	// Subtract-and-compare flag update; Z is sticky-low for the carry form
	function automatic logic [7:0] cmp_flags(input logic [7:0] a, input logic [7:0] b,
			input logic cin, input logic chain_z, input logic [7:0] fin);
		logic [7:0] r;
		logic [7:0] f;
		r = a - b - {7'h00, cin};
		f = fin;
		f[FLAG_H] = (~a[3] & b[3]) | (b[3] & r[3]) | (r[3] & ~a[3]);
		f[FLAG_V] = (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]);
		f[FLAG_N] = r[7];
		f[FLAG_Z] = chain_z ? (~|r & fin[FLAG_Z]) : ~|r;
		f[FLAG_C] = (~a[7] & b[7]) | (b[7] & r[7]) | (r[7] & ~a[7]);
		return f;
	endfunction

	// Skip distance depends on the width of the instruction skipped
	function automatic logic [PC_W-1:0] skip_pc(input logic [PC_W-1:0] pc,
			input logic two_word);
		return pc + (two_word ? 16'h0003 : 16'h0002);
	endfunction

	function automatic logic [CNT_W-1:0] skip_cyc(input logic two_word);
		return two_word ? CYC_THREE : CYC_TWO;
	endfunction

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	pfb_state_t s_q;
	pfb_state_t s_d;

	logic [PC_W-1:0] pc_next_seq;
	logic [PC_W-1:0] pc_rel;
	logic            take;
	logic            is_skip;
	logic            is_branch;
	logic [PC_W-1:0] new_pc;
	logic [7:0]      new_flags;
	logic            new_flags_we;
	logic [CNT_W-1:0] cyc;
	logic            new_push;

	always_comb begin
		pc_next_seq  = s_q.pc + 16'h0001;
		pc_rel       = pc_next_seq + PC_W'(ISSUE_IN.offset);
		take         = 1'b0;
		is_skip      = 1'b0;
		is_branch    = 1'b0;
		new_pc       = pc_next_seq;
		new_flags    = FLAGS_IN;
		new_flags_we = 1'b0;
		cyc          = CYC_ONE;
		new_push     = 1'b0;

		unique case (ISSUE_IN.op)
			relative_jump_op: begin
				new_pc = pc_rel;
				cyc    = CYC_TWO;                                   // [RULE19]
			end
			indirect_jump_op: begin
				new_pc = Z_PTR_IN;                                  // [RULE1]
				cyc    = CYC_TWO;                                   // [RULE1]
			end
			absolute_jump_op: begin
				new_pc = ISSUE_IN.target;
				cyc    = CYC_THREE;                                 // [RULE19]
			end
			relative_subroutine_invoke_op: begin
				new_pc   = pc_rel;
				new_push = 1'b1;
				cyc      = CYC_THREE;                               // [RULE19]
			end
			indirect_subroutine_invoke_op: begin
				new_pc   = Z_PTR_IN;                                // [RULE2]
				new_push = 1'b1;
				cyc      = CYC_THREE;                               // [RULE2]
			end
			direct_subroutine_invoke_op: begin
				// Two-word instruction: return lands past the address word
				new_pc   = ISSUE_IN.target;
				new_push = 1'b1;
				cyc      = CYC_FOUR;                                // [RULE19]
			end
			subroutine_exit_op: begin
				new_pc = STACK_IN;                                  // [RULE20]
				cyc    = CYC_FOUR;                                  // [RULE20]
			end
			interrupt_exit_op: begin
				new_pc               = STACK_IN;                    // [RULE20]
				new_flags[FLAG_I]    = 1'b1;                        // [RULE20]
				new_flags_we         = 1'b1;
				cyc                  = CYC_FOUR;                    // [RULE20]
			end
			compare_skip_equal_op: begin
				is_skip = 1'b1;
				take    = ISSUE_IN.rd_val == ISSUE_IN.rr_val;       // [RULE3]
			end
			compare_op: begin
				new_flags    = cmp_flags(ISSUE_IN.rd_val, ISSUE_IN.rr_val, 1'b0, 1'b0,
					FLAGS_IN);
				new_flags_we = 1'b1;
			end
			compare_carry_op: begin
				new_flags    = cmp_flags(ISSUE_IN.rd_val, ISSUE_IN.rr_val,
					FLAGS_IN[FLAG_C], 1'b1, FLAGS_IN);
				new_flags_we = 1'b1;
			end
			compare_immediate_op: begin
				// No register write-back leaves this unit
				new_flags    = cmp_flags(ISSUE_IN.rd_val, ISSUE_IN.rr_val, 1'b0, 1'b0,
					FLAGS_IN);                                      // [RULE4]
				new_flags_we = 1'b1;                                // [RULE4]
			end
			skip_reg_bit_clear_op: begin
				is_skip = 1'b1;
				take    = ~ISSUE_IN.rr_val[ISSUE_IN.bit_sel];       // [RULE5]
			end
			skip_reg_bit_set_op: begin
				is_skip = 1'b1;
				take    = ISSUE_IN.rr_val[ISSUE_IN.bit_sel];        // [RULE6]
			end
			skip_io_bit_clear_op: begin
				is_skip = 1'b1;
				take    = ~ISSUE_IN.io_val[ISSUE_IN.bit_sel];       // [RULE7]
			end
			skip_io_bit_set_op: begin
				is_skip = 1'b1;
				take    = ISSUE_IN.io_val[ISSUE_IN.bit_sel];        // [RULE8]
			end
			branch_flag_set_op: begin
				is_branch = 1'b1;
				take      = FLAGS_IN[ISSUE_IN.bit_sel];             // [RULE9]
			end
			branch_flag_clear_op: begin
				is_branch = 1'b1;
				take      = ~FLAGS_IN[ISSUE_IN.bit_sel];            // [RULE10]
			end
			branch_unsigned_ge_op: begin
				is_branch = 1'b1;
				take      = ~FLAGS_IN[FLAG_C];                      // [RULE11]
			end
			branch_signed_ge_op: begin
				is_branch = 1'b1;
				take      = ~(FLAGS_IN[FLAG_N] ^ FLAGS_IN[FLAG_V]); // [RULE12]
			end
			branch_signed_lt_op: begin
				is_branch = 1'b1;
				take      = FLAGS_IN[FLAG_N] ^ FLAGS_IN[FLAG_V];    // [RULE13]
			end
			branch_half_carry_set_op: begin
				is_branch = 1'b1;
				take      = FLAGS_IN[FLAG_H];                       // [RULE14]
			end
			branch_half_carry_clear_op: begin
				is_branch = 1'b1;
				take      = ~FLAGS_IN[FLAG_H];                      // [RULE15]
			end
			branch_transfer_bit_clear_op: begin
				is_branch = 1'b1;
				take      = ~FLAGS_IN[FLAG_T];                      // [RULE16]
			end
			branch_overflow_set_op: begin
				is_branch = 1'b1;
				take      = FLAGS_IN[FLAG_V];                       // [RULE17]
			end
			branch_overflow_clear_op: begin
				is_branch = 1'b1;
				take      = ~FLAGS_IN[FLAG_V];                      // [RULE18]
			end
			no_flow_op: begin
			end
			default: begin
			end
		endcase

		// Skips: PC plus 2 or 3 and 2 or 3 cycles when taken
		if (is_skip && take) begin
			new_pc = skip_pc(s_q.pc, ISSUE_IN.next_two_word);       // [RULE3] [RULE5] [RULE7]
			cyc    = skip_cyc(ISSUE_IN.next_two_word);              // [RULE6] [RULE8]
		end
		// Branches: PC plus k plus 1, one extra cycle when taken
		if (is_branch && take) begin
			new_pc = pc_rel;                                        // [RULE9] [RULE10] [RULE11]
			cyc    = CYC_TWO;                                       // [RULE13] [RULE14] [RULE17]
		end
	end

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	// Results are held back until the last cycle so the PC the fetch
	// side sees never moves mid-instruction.
	always_comb begin
		s_d          = s_q;
		s_d.done     = 1'b0;
		s_d.flags_we = 1'b0;
		s_d.push     = 1'b0;

		if (s_q.busy) begin
			s_d.cnt = s_q.cnt - CYC_ONE;
			if (s_q.cnt == CYC_ONE) begin
				s_d.busy     = 1'b0;
				s_d.done     = 1'b1;
				s_d.pc       = s_q.pend_pc;
				s_d.flags    = s_q.pend_flags;
				s_d.flags_we = s_q.pend_flags_we;
			end
		end else if (ISSUE_IN.valid) begin
			// Return address and push go out on the issue cycle
			s_d.push     = new_push;
			s_d.ret_addr = (ISSUE_IN.op == direct_subroutine_invoke_op) ?
				s_q.pc + 16'h0002 : pc_next_seq;
			if (cyc == CYC_ONE) begin
				s_d.done     = 1'b1;
				s_d.pc       = new_pc;
				s_d.flags    = new_flags;
				s_d.flags_we = new_flags_we;
			end else begin
				s_d.busy          = 1'b1;
				s_d.cnt           = cyc - CYC_ONE;
				s_d.pend_pc       = new_pc;
				s_d.pend_flags    = new_flags;
				s_d.pend_flags_we = new_flags_we;
			end
		end
	end

	always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			s_q <= '{pc: PC_RESET, pend_pc: PC_RESET, flags: FLAGS_RESET,
				pend_flags: FLAGS_RESET, pend_flags_we: 1'b0, cnt: '0, busy: 1'b0,
				done: 1'b0, flags_we: 1'b0, push: 1'b0, ret_addr: PC_RESET};
		end else begin
			s_q <= s_d;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign PC_OUT       = s_q.pc;
	assign FLAGS_OUT    = s_q.flags;
	assign FLAGS_WE_OUT = s_q.flags_we;
	assign BUSY_OUT     = s_q.busy;
	assign DONE_OUT     = s_q.done;
	assign PUSH_OUT     = s_q.push;
	assign RET_ADDR_OUT = s_q.ret_addr;

endmodule // pfb_branch_unit

`default_nettype wire

/* rtl/pfb_pkg.sv */
// Package for the program-flow branch unit: operation codes, status bit
// positions, cycle counts and the issue / state carriers.
// Assumes an 8-bit core that decodes instructions elsewhere on one clock.
`default_nettype none

package pfb_pkg;

	// ----------------------------------------------------------------
	// Widths
	// ----------------------------------------------------------------
	localparam int PC_W   = 16;
	localparam int OFS_W  = 12;
	localparam int CNT_W  = 3;

	// ----------------------------------------------------------------
	// Status flag bit positions
	// ----------------------------------------------------------------
	localparam int FLAG_C = 0;
	localparam int FLAG_Z = 1;
	localparam int FLAG_N = 2;
	localparam int FLAG_V = 3;
	localparam int FLAG_S = 4;
	localparam int FLAG_H = 5;
	localparam int FLAG_T = 6;
	localparam int FLAG_I = 7;

	// ----------------------------------------------------------------
	// Cycle counts
	// ----------------------------------------------------------------
	localparam logic [CNT_W-1:0] CYC_ONE   = 3'h1;
	localparam logic [CNT_W-1:0] CYC_TWO   = 3'h2;
	localparam logic [CNT_W-1:0] CYC_THREE = 3'h3;
	localparam logic [CNT_W-1:0] CYC_FOUR  = 3'h4;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [PC_W-1:0]  PC_RESET   = 16'h0000;
	localparam logic [7:0]       FLAGS_RESET = 8'h00;

	// ----------------------------------------------------------------
	// Operations
	// ----------------------------------------------------------------
	typedef enum logic [4:0] {
		relative_jump_op,
		indirect_jump_op,
		absolute_jump_op,
		relative_subroutine_invoke_op,
		indirect_subroutine_invoke_op,
		direct_subroutine_invoke_op,
		subroutine_exit_op,
		interrupt_exit_op,
		compare_skip_equal_op,
		compare_op,
		compare_carry_op,
		compare_immediate_op,
		skip_reg_bit_clear_op,
		skip_reg_bit_set_op,
		skip_io_bit_clear_op,
		skip_io_bit_set_op,
		branch_flag_set_op,
		branch_flag_clear_op,
		branch_unsigned_ge_op,
		branch_signed_ge_op,
		branch_signed_lt_op,
		branch_half_carry_set_op,
		branch_half_carry_clear_op,
		branch_transfer_bit_clear_op,
		branch_overflow_set_op,
		branch_overflow_clear_op,
		no_flow_op
	} pfb_op_t;

	// Decoded instruction handed over by the decoder
	typedef struct packed {
		logic                    valid;
		pfb_op_t                 op;
		logic signed [OFS_W-1:0] offset;       // k, sign-extended
		logic [2:0]              bit_sel;      // b or s
		logic [7:0]              rd_val;
		logic [7:0]              rr_val;       // also the immediate K
		logic [7:0]              io_val;
		logic [PC_W-1:0]         target;       // absolute jump / invoke
		logic                    next_two_word;
	} pfb_issue_t;

	// Whole state of the unit
	typedef struct packed {
		logic [PC_W-1:0]  pc;
		logic [PC_W-1:0]  pend_pc;
		logic [7:0]       flags;
		logic [7:0]       pend_flags;
		logic             pend_flags_we;
		logic [CNT_W-1:0] cnt;
		logic             busy;
		logic             done;
		logic             flags_we;
		logic             push;
		logic [PC_W-1:0]  ret_addr;
	} pfb_state_t;

endpackage : pfb_pkg

`default_nettype wire

/* testbench/pfb_branch_unit_checker.sv */
// Concurrent checks on the ports of the program-flow branch unit.
// Assumes one clock and the active-low asynchronous reset of the unit.
`default_nettype none

module pfb_branch_unit_checker (
	input wire logic                       CLK_IN,
	input wire logic                       RESETN_IN,
	input wire pfb_pkg::pfb_issue_t        ISSUE_IN,
	input wire logic [7:0]                 FLAGS_IN,
	input wire logic [pfb_pkg::PC_W-1:0]   Z_PTR_IN,
	input wire logic [pfb_pkg::PC_W-1:0]   STACK_IN,
	input wire logic [pfb_pkg::PC_W-1:0]   PC_OUT,
	input wire logic [7:0]                 FLAGS_OUT,
	input wire logic                       FLAGS_WE_OUT,
	input wire logic                       BUSY_OUT,
	input wire logic                       DONE_OUT,
	input wire logic                       PUSH_OUT,
	input wire logic [pfb_pkg::PC_W-1:0]   RET_ADDR_OUT
);
	timeunit 1ns;
	timeprecision 100ps;
	import pfb_pkg::*;

	default clocking cb @(posedge CLK_IN);
	endclocking
	default disable iff (!RESETN_IN);

	// Issue is only taken while idle
	logic tk;
	assign tk = ISSUE_IN.valid && !BUSY_OUT;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	a_indirect_jump_op_loads_z: assert property (tk && ISSUE_IN.op == indirect_jump_op |=> !DONE_OUT ##1
		(DONE_OUT && !FLAGS_WE_OUT && PC_OUT == $past(Z_PTR_IN, 2)))
		else $error("indirect jump result wrong");
	a_indirect_subroutine_invoke_op_loads_z: assert property (tk && ISSUE_IN.op == indirect_subroutine_invoke_op |=>
		!DONE_OUT [*2] ##1 (DONE_OUT && PC_OUT == $past(Z_PTR_IN, 3)))
		else $error("indirect invoke result wrong");
	a_compare_skip_equal_op_skip_one: assert property (tk && ISSUE_IN.op == compare_skip_equal_op &&
		ISSUE_IN.rd_val == ISSUE_IN.rr_val && !ISSUE_IN.next_two_word |=> !DONE_OUT ##1
		(DONE_OUT && PC_OUT == $past(PC_OUT, 2) + 16'h0002))
		else $error("compare skip result wrong");
	a_cpi_one_cycle: assert property (tk && ISSUE_IN.op == compare_immediate_op |=>
		DONE_OUT && FLAGS_WE_OUT && !BUSY_OUT)
		else $error("compare immediate timing wrong");
	a_skip_io_long: assert property (tk && ISSUE_IN.op == skip_io_bit_set_op &&
		ISSUE_IN.io_val[ISSUE_IN.bit_sel] && ISSUE_IN.next_two_word |=> !DONE_OUT [*2] ##1
		(DONE_OUT && PC_OUT == $past(PC_OUT, 3) + 16'h0003))
		else $error("io skip result wrong");
	a_ovs_untaken: assert property (tk && ISSUE_IN.op == branch_overflow_set_op &&
		!FLAGS_IN[FLAG_V] |=> DONE_OUT && !FLAGS_WE_OUT && PC_OUT == $past(PC_OUT) + 16'h0001)
		else $error("untaken branch result wrong");
	a_ovc_taken: assert property (tk && ISSUE_IN.op == branch_overflow_clear_op &&
		!FLAGS_IN[FLAG_V] |=> BUSY_OUT ##1 (DONE_OUT && PC_OUT == $past(PC_OUT, 2)
		+ 16'($past(ISSUE_IN.offset, 2)) + 16'h0001))
		else $error("taken branch result wrong");
	a_call_push_ret: assert property (tk && ISSUE_IN.op == direct_subroutine_invoke_op |=>
		(PUSH_OUT && RET_ADDR_OUT == $past(PC_OUT) + 16'h0002) ##3
		(DONE_OUT && PC_OUT == $past(ISSUE_IN.target, 4)))
		else $error("direct invoke result wrong");
	a_interrupt_exit_op_sets_i: assert property (tk && ISSUE_IN.op == interrupt_exit_op |=> BUSY_OUT [*3]
		##1 (DONE_OUT && FLAGS_WE_OUT && FLAGS_OUT[FLAG_I] && PC_OUT == $past(STACK_IN, 4)))
		else $error("interrupt exit result wrong");

endmodule // pfb_branch_unit_checker

bind pfb_branch_unit pfb_branch_unit_checker u_chk (.CLK_IN(CLK_IN), .RESETN_IN(RESETN_IN),
	.ISSUE_IN(ISSUE_IN), .FLAGS_IN(FLAGS_IN), .Z_PTR_IN(Z_PTR_IN), .STACK_IN(STACK_IN),
	.PC_OUT(PC_OUT), .FLAGS_OUT(FLAGS_OUT), .FLAGS_WE_OUT(FLAGS_WE_OUT), .BUSY_OUT(BUSY_OUT),
	.DONE_OUT(DONE_OUT), .PUSH_OUT(PUSH_OUT), .RET_ADDR_OUT(RET_ADDR_OUT));

`default_nettype wire

/* testbench/pfb_branch_unit_tb.sv */
// Self-checking bench for the program-flow branch unit.
// Assumes the unit's package is compiled first; drives all ports itself.
`default_nettype none

`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin bad_count++; \
	$display("unexpected at %0t: got %h want %h", $time, (a), (e)); end end

module pfb_branch_unit_tb;
	timeunit 1ns;
	timeprecision 100ps;
	import pfb_pkg::*;

	typedef struct {
		pfb_op_t     op;
		logic [7:0]  fl, rd, rr;
		logic [2:0]  b;
		logic        tw;
		int          n;
		logic        a;
		logic [15:0] pc;
	} pfb_row_t;

	logic        clk, resetn, fwe_o, busy_o, done_o, push_o;
	pfb_issue_t  iss;
	logic [7:0]  fl, fo;
	logic [15:0] z, stk, pc_o, ret_o, p0;
	int          bad_count, tests_run, cyc;
	pfb_row_t    rows[28];

	pfb_branch_unit dut (.CLK_IN(clk), .RESETN_IN(resetn), .ISSUE_IN(iss), .FLAGS_IN(fl),
		.Z_PTR_IN(z), .STACK_IN(stk), .PC_OUT(pc_o), .FLAGS_OUT(fo), .FLAGS_WE_OUT(fwe_o),
		.BUSY_OUT(busy_o), .DONE_OUT(done_o), .PUSH_OUT(push_o), .RET_ADDR_OUT(ret_o));

	always #4 clk = ~clk;

	// Hang guard: whole run needs about 115 cycles
	always @(posedge clk) begin
		cyc++;
		if (cyc >= 2000) begin
			bad_count++;
			final_report();
		end
	end

	task automatic final_report;
		$display("comparisons %0d, mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// ----------------------------------------------------------------
	// One instruction: issue, wait for done, compare
	// ----------------------------------------------------------------
	task automatic run(input pfb_row_t r);
		int c;
		@(posedge clk) #1;
		iss = '{1'b1, r.op, 12'hffc, r.b, r.rd, r.rr, r.rd, 16'h0789, r.tw};
		fl = r.fl;
		p0 = pc_o;
		c = 1;
		@(posedge clk) #1;
		iss.valid = 1'b0;
		`CHK(busy_o, r.n > 1)
		`CHK(push_o, (r.op inside {relative_subroutine_invoke_op, indirect_subroutine_invoke_op, direct_subroutine_invoke_op}))
		`CHK(ret_o, p0 + ((r.op == direct_subroutine_invoke_op) ? 16'h0002 : 16'h0001))
		while (done_o !== 1'b1 && c < 8) begin
			@(posedge clk) #1;
			c++;
		end
		`CHK(c, r.n)
		`CHK(pc_o, r.a ? r.pc : p0 + r.pc)
		`CHK(fwe_o, (r.op == compare_immediate_op || r.op == interrupt_exit_op))
		// Compare of 0x10 with 0x20 borrows and goes negative
		`CHK(fo, r.op == compare_immediate_op ? 8'h05 :
			(r.op == interrupt_exit_op ? (r.fl | 8'h80) : r.fl))
	endtask

	initial begin
		clk = 1'b0;
		resetn = 1'b0;
		iss = '0;
		fl = 8'h00;
		z = 16'h1230;
		stk = 16'h0456;
		rows = '{
			'{relative_jump_op,8'h00,8'h00,8'h00,3'h0,1'b0,2,1'b0,16'hfffd},
			'{indirect_jump_op,8'h00,8'h00,8'h00,3'h0,1'b0,2,1'b1,16'h1230},
			'{absolute_jump_op,8'h00,8'h00,8'h00,3'h0,1'b0,3,1'b1,16'h0789},
			'{relative_subroutine_invoke_op,8'h00,8'h00,8'h00,3'h0,1'b0,3,1'b0,16'hfffd},
			'{indirect_subroutine_invoke_op,8'h00,8'h00,8'h00,3'h0,1'b0,3,1'b1,16'h1230},
			'{direct_subroutine_invoke_op,8'h00,8'h00,8'h00,3'h0,1'b0,4,1'b1,16'h0789},
			'{subroutine_exit_op,8'h00,8'h00,8'h00,3'h0,1'b0,4,1'b1,16'h0456},
			'{interrupt_exit_op,8'h00,8'h00,8'h00,3'h0,1'b0,4,1'b1,16'h0456},
			'{compare_skip_equal_op,8'h00,8'h5a,8'h5a,3'h0,1'b0,2,1'b0,16'h0002},
			'{compare_skip_equal_op,8'h00,8'h5a,8'h5a,3'h0,1'b1,3,1'b0,16'h0003},
			'{compare_skip_equal_op,8'h00,8'h5a,8'h5b,3'h0,1'b1,1,1'b0,16'h0001},
			'{compare_immediate_op,8'h00,8'h10,8'h20,3'h0,1'b0,1,1'b0,16'h0001},
			'{skip_reg_bit_clear_op,8'h00,8'hf7,8'hf7,3'h3,1'b0,2,1'b0,16'h0002},
			'{skip_reg_bit_set_op,8'h00,8'hf7,8'hf7,3'h3,1'b1,1,1'b0,16'h0001},
			'{skip_reg_bit_set_op,8'h00,8'h08,8'h08,3'h3,1'b1,3,1'b0,16'h0003},
			'{skip_io_bit_clear_op,8'h00,8'h7f,8'h7f,3'h7,1'b0,2,1'b0,16'h0002},
			'{skip_io_bit_set_op,8'h00,8'h80,8'h80,3'h7,1'b1,3,1'b0,16'h0003},
			'{branch_flag_set_op,8'h40,8'h00,8'h00,3'h6,1'b0,2,1'b0,16'hfffd},
			'{branch_flag_clear_op,8'h40,8'h00,8'h00,3'h6,1'b0,1,1'b0,16'h0001},
			'{branch_unsigned_ge_op,8'h01,8'h00,8'h00,3'h0,1'b0,1,1'b0,16'h0001},
			'{branch_signed_ge_op,8'h08,8'h00,8'h00,3'h0,1'b0,1,1'b0,16'h0001},
			'{branch_signed_ge_op,8'h0c,8'h00,8'h00,3'h0,1'b0,2,1'b0,16'hfffd},
			'{branch_signed_lt_op,8'h08,8'h00,8'h00,3'h0,1'b0,2,1'b0,16'hfffd},
			'{branch_half_carry_set_op,8'h20,8'h00,8'h00,3'h0,1'b0,2,1'b0,16'hfffd},
			'{branch_half_carry_clear_op,8'h20,8'h00,8'h00,3'h0,1'b0,1,1'b0,16'h0001},
			'{branch_transfer_bit_clear_op,8'h00,8'h00,8'h00,3'h0,1'b0,2,1'b0,16'hfffd},
			'{branch_overflow_set_op,8'h08,8'h00,8'h00,3'h0,1'b0,2,1'b0,16'hfffd},
			'{branch_overflow_clear_op,8'h00,8'h00,8'h00,3'h0,1'b0,2,1'b0,16'hfffd}};
		repeat (12) @(posedge clk);
		#1;
		`CHK(pc_o, 16'h0000)
		resetn = 1'b1;
		foreach (rows[i]) begin
			run(rows[i]);
		end
		// ------------------------------------------------------------
		// Register compares and a plain instruction, back to back
		// ------------------------------------------------------------
		// Zero result with Z low beforehand must keep Z low
		@(posedge clk) #1;
		iss = '{1'b1, compare_carry_op, 12'hffc, 3'h0, 8'h20, 8'h1f, 8'h00, 16'h0789, 1'b0};
		fl = 8'h01;
		p0 = pc_o;
		@(posedge clk) #1;
		`CHK({done_o, fwe_o, fo}, {2'b11, 8'h20})
		iss.op = compare_op;
		iss.rr_val = 8'h20;
		fl = 8'h00;
		@(posedge clk) #1;
		`CHK({done_o, fwe_o, fo}, {2'b11, 8'h02})
		iss.op = no_flow_op;
		@(posedge clk) #1;
		iss.valid = 1'b0;
		`CHK({done_o, fwe_o, pc_o}, {2'b10, p0 + 16'h0003})
		// ------------------------------------------------------------
		// Refused issue while busy
		// ------------------------------------------------------------
		@(posedge clk) #1;
		iss.op = relative_jump_op;
		iss.valid = 1'b1;
		p0 = pc_o;
		@(posedge clk) #1;
		iss.op = compare_immediate_op;
		@(posedge clk) #1;
		iss.valid = 1'b0;
		`CHK(done_o, 1'b1)
		`CHK(pc_o, p0 + 16'hfffd)
		@(posedge clk) #1;
		`CHK(fwe_o, 1'b0)
		// ------------------------------------------------------------
		// Back-to-back untaken branches, no idle cycle between
		// ------------------------------------------------------------
		iss.op = branch_overflow_set_op;
		fl = 8'h00;
		iss.valid = 1'b1;
		p0 = pc_o;
		@(posedge clk) #1;
		`CHK(pc_o, p0 + 16'h0001)
		@(posedge clk) #1;
		iss.valid = 1'b0;
		`CHK(pc_o, p0 + 16'h0002)
		`CHK(done_o, 1'b1)
		// ------------------------------------------------------------
		// Reset in the middle of a direct invoke
		// ------------------------------------------------------------
		@(posedge clk) #1;
		iss.op = direct_subroutine_invoke_op;
		iss.valid = 1'b1;
		@(posedge clk) #1;
		iss.valid = 1'b0;
		`CHK(push_o, 1'b1)
		resetn = 1'b0;
		#1;
		`CHK({pc_o, fo, ret_o, busy_o, push_o}, 42'h0)
		@(posedge clk) #1;
		resetn = 1'b1;
		// Nothing may be left in flight from the cut invoke
		@(posedge clk) #1;
		`CHK({pc_o, busy_o, done_o, push_o}, 19'h0)
		final_report();
	end
endmodule // pfb_branch_unit_tb

`default_nettype wire
